// ### hw/wwd_pkg.sv
// Shared constants, register map and types of the windowed watchdog
package wwd_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int PRE_W = 7;
    localparam int POST_W = 16;
    localparam int INT_W = 3;

    // Register offsets
    localparam logic [ADDR_W-1:0] REG_RSTCTL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h4;
    localparam logic [ADDR_W-1:0] REG_INTSTAT = 4'h8;
    localparam logic [ADDR_W-1:0] REG_INTMASK = 4'hc;

    // reset_control_reg fields
    localparam int RC_IDLE_BIT = 2;
    localparam int RC_SLEEP_BIT = 3;
    localparam int RC_TOFLAG_BIT = 4;
    localparam int RC_SWEN_BIT = 5;
    localparam logic [DATA_W-1:0] RC_WRITE_MASK = 16'h003c;
    localparam logic [DATA_W-1:0] RSTCTL_RESET = 16'h0000;

    // watchdog_config_word fields
    localparam int CFG_POST_LSB = 0;
    localparam int CFG_PRE_BIT = 4;
    localparam int CFG_WINDOW_MODE_DISABLE_BIT = 7;
    localparam int CFG_WINSEL_LSB = 8;
    localparam int CFG_EN_LSB = 10;
    localparam logic [DATA_W-1:0] CFG_WRITE_MASK = 16'h0f9f;
    localparam logic [DATA_W-1:0] CONFIG_RESET = 16'h089f;

    // watchdog_enable_config encodings
    localparam logic [1:0] EN_ALWAYS = 2'h3;
    localparam logic [1:0] EN_SOFT = 2'h2;

    // Interrupt status / mask bits
    localparam int INT_TIMEOUT = 0;
    localparam int INT_WAKE = 1;
    localparam int INT_WINFAULT = 2;
    localparam logic [INT_W-1:0] INT_RESET = 3'h0;

    // Prescaler terminal counts: divide by 32 or by 128
    localparam logic [PRE_W-1:0] PRE_LAST_32 = 7'h1f;
    localparam logic [PRE_W-1:0] PRE_LAST_128 = 7'h7f;

    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_DOZE = 2'h1,
        ST_RESUME = 2'h3
    } wwd_state_t;

endpackage : wwd_pkg

// ### hw/wwd_tb_if.sv
// Link between the watchdog control logic and its time base
interface wwd_tb_if;
    logic tick;
    logic run;
    logic clear;
    logic preSel;
    logic [3:0] postSel;
    logic [1:0] winSel;
    logic timeout;
    logic windowOpen;

    modport ctrl (output tick, run, clear, preSel, postSel, winSel, input timeout, windowOpen);
    modport tb (input tick, run, clear, preSel, postSel, winSel, output timeout, windowOpen);
endinterface : wwd_tb_if

// ### hw/wwd_timebase.sv
// Prescaler, postscaler and window decode of the watchdog
module wwd_timebase (
    input wire logic clk,
    input wire logic rstn,
    wwd_tb_if.tb tb
);
    logic [wwd_pkg::PRE_W-1:0] preCnt;
    logic [wwd_pkg::POST_W-1:0] postCnt;
    logic [wwd_pkg::PRE_W-1:0] preLast;
    logic [wwd_pkg::POST_W-1:0] postPeriod;
    logic [wwd_pkg::POST_W-1:0] winThresh;
    logic preWrap;
    logic postWrap;

    assign preLast = tb.preSel ? wwd_pkg::PRE_LAST_128 : wwd_pkg::PRE_LAST_32;
    assign postPeriod = 16'h0001 << tb.postSel;
    assign winThresh = postPeriod - (postPeriod >> ({1'b0, tb.winSel} + 3'h1));
    assign preWrap = tb.tick && (preCnt == preLast);
    assign postWrap = preWrap && (postCnt == postPeriod - 16'h0001);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            preCnt <= '0;
        end else if (tb.clear || !tb.run) begin
            preCnt <= '0;
        end else if (tb.tick) begin
            preCnt <= preWrap ? '0 : preCnt + 7'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            postCnt <= '0;
        end else if (tb.clear || !tb.run) begin
            postCnt <= '0;
        end else if (preWrap) begin
            postCnt <= postWrap ? '0 : postCnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tb.timeout <= 1'b0;
        end else begin
            tb.timeout <= tb.run && !tb.clear && postWrap;
        end
    end

    // A 1:1 postscaler leaves no room for a window, so it is always open
    assign tb.windowOpen = (tb.postSel == 4'h0) || (postCnt >= winThresh);

    AST_CLEAR_ZEROES: assert property (@(posedge clk) disable iff (!rstn)
        tb.clear |=> (preCnt == '0) && (postCnt == '0))
        else $error("Counters not cleared");

    AST_PRE_LIMIT: assert property (@(posedge clk) disable iff (!rstn)
        preCnt <= preLast || $changed(tb.preSel))
        else $error("Prescaler beyond its terminal count");

    AST_POST_LIMIT: assert property (@(posedge clk) disable iff (!rstn)
        (postCnt < postPeriod) || $changed(tb.postSel))
        else $error("Postscaler beyond its period");
endmodule : wwd_timebase

// ### hw/wwd_watchdog.sv
// Windowed watchdog: enable logic, low-power handling, registers, interrupt
// How it works
// - Keeps counting in sleep and idle
// - Time-out in low power wakes the core
// - Enable config 11 forces watchdog on
// - Enable config 10 follows software enable
// - Every device reset clears software enable
// - Time-out flag set by hardware, cleared by firmware
// - Window-disable bit zero selects windowed mode
// - Low-power oscillator on while enabled
// - Prescaler divides by 32 or 128
// - Sixteen postscaler ratios 1:1 to 1:32768
// - Counters cleared on reset, switch, power transitions, clear
module wwd_watchdog (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [wwd_pkg::ADDR_W-1:0] regAddr,
    input wire logic [wwd_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [wwd_pkg::DATA_W-1:0] regRdata,
    input wire logic lowPowerOsc,
    input wire logic powerSaveInstr,
    input wire logic powerSaveSleep,
    input wire logic clearInstr,
    input wire logic clockSwitchDone,
    input wire logic otherWake,
    output logic oscEnable,
    output logic wakeRequest,
    output logic deviceReset,
    output logic lowPower,
    output logic irq
);
    wwd_tb_if tbLink ();

    wwd_pkg::wwd_state_t state;
    wwd_pkg::wwd_state_t next_state;
    logic [wwd_pkg::DATA_W-1:0] config_word;
    logic [wwd_pkg::INT_W-1:0] intStatus;
    logic [wwd_pkg::INT_W-1:0] intMask;
    logic [wwd_pkg::INT_W-1:0] intEvent;
    logic swEnable;
    logic timeoutFlag;
    logic sleepFlag;
    logic idleFlag;
    logic oscMeta;
    logic oscSync;
    logic oscLast;
    logic [1:0] enableCfg;
    logic windowed;
    logic enabled;
    logic runClear;
    logic windowFault;
    logic runTimeout;
    logic dozeTimeout;
    logic issueReset;
    logic wrRstCtl;
    logic wrConfig;

    assign enableCfg = config_word[wwd_pkg::CFG_EN_LSB +: 2];
    assign windowed = !config_word[wwd_pkg::CFG_WINDOW_MODE_DISABLE_BIT];
    assign enabled = (enableCfg == wwd_pkg::EN_ALWAYS) ||
        ((enableCfg == wwd_pkg::EN_SOFT) && swEnable);
    assign wrRstCtl = regWrite && (regAddr == wwd_pkg::REG_RSTCTL);
    assign wrConfig = regWrite && (regAddr == wwd_pkg::REG_CONFIG);

    assign runClear = clearInstr && (state == wwd_pkg::ST_RUN);
    assign windowFault = runClear && enabled && windowed && !tbLink.windowOpen;
    assign runTimeout = tbLink.timeout && (state == wwd_pkg::ST_RUN);
    assign dozeTimeout = tbLink.timeout && (state == wwd_pkg::ST_DOZE);
    assign issueReset = runTimeout || windowFault;

    // Oscillator pin is synchronised before its edges are counted
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oscMeta <= 1'b0;
            oscSync <= 1'b0;
            oscLast <= 1'b0;
        end else begin
            oscMeta <= lowPowerOsc;
            oscSync <= oscMeta;
            oscLast <= oscSync;
        end
    end

    assign tbLink.tick = oscSync && !oscLast;
    assign tbLink.run = enabled;
    // A new configuration restarts the time base so no count exceeds its new limit
    assign tbLink.clear = runClear || powerSaveInstr || clockSwitchDone ||
        (state == wwd_pkg::ST_RESUME) || issueReset || dozeTimeout || wrConfig;
    assign tbLink.preSel = config_word[wwd_pkg::CFG_PRE_BIT];
    assign tbLink.postSel = config_word[wwd_pkg::CFG_POST_LSB +: 4];
    assign tbLink.winSel = config_word[wwd_pkg::CFG_WINSEL_LSB +: 2];

    wwd_timebase timebase (
        .clk(clk),
        .rstn(rstn),
        .tb(tbLink.tb)
    );

    // Low-power state tracking
    always_comb begin
        next_state = state;
        case (state)
            wwd_pkg::ST_RUN: begin
                if (powerSaveInstr && !issueReset) begin
                    next_state = wwd_pkg::ST_DOZE;
                end
            end
            wwd_pkg::ST_DOZE: begin
                if (dozeTimeout || otherWake) begin
                    next_state = wwd_pkg::ST_RESUME;
                end
            end
            wwd_pkg::ST_RESUME: begin
                next_state = wwd_pkg::ST_RUN;
            end
            default: begin
                next_state = wwd_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= wwd_pkg::ST_RUN;
            lowPower <= 1'b0;
        end else begin
            state <= next_state;
            lowPower <= (next_state == wwd_pkg::ST_DOZE);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wakeRequest <= 1'b0;
            deviceReset <= 1'b0;
            oscEnable <= 1'b0;
        end else begin
            wakeRequest <= dozeTimeout;
            deviceReset <= issueReset;
            oscEnable <= enabled;
        end
    end

    // Software enable: cleared by reset and by the reset this block issues
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            swEnable <= 1'b0;
        end else if (issueReset) begin
            swEnable <= 1'b0;
        end else if (wrRstCtl) begin
            swEnable <= regWdata[wwd_pkg::RC_SWEN_BIT];
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            timeoutFlag <= 1'b0;
        end else if (tbLink.timeout || windowFault) begin
            timeoutFlag <= 1'b1;
        end else if (wrRstCtl) begin
            timeoutFlag <= regWdata[wwd_pkg::RC_TOFLAG_BIT];
        end
    end

    // Sleep and idle flags stay set after a wake until firmware clears them
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sleepFlag <= 1'b0;
            idleFlag <= 1'b0;
        end else if (powerSaveInstr && state == wwd_pkg::ST_RUN && !issueReset) begin
            sleepFlag <= powerSaveSleep || (wrRstCtl ? regWdata[wwd_pkg::RC_SLEEP_BIT] : sleepFlag);
            idleFlag <= !powerSaveSleep || (wrRstCtl ? regWdata[wwd_pkg::RC_IDLE_BIT] : idleFlag);
        end else if (wrRstCtl) begin
            sleepFlag <= regWdata[wwd_pkg::RC_SLEEP_BIT];
            idleFlag <= regWdata[wwd_pkg::RC_IDLE_BIT];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            config_word <= wwd_pkg::CONFIG_RESET;
        end else if (wrConfig) begin
            config_word <= regWdata & wwd_pkg::CFG_WRITE_MASK;
        end
    end

    // Interrupt status: write one to clear, a new event wins
    assign intEvent = {windowFault, dozeTimeout, runTimeout};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            intStatus <= wwd_pkg::INT_RESET;
        end else if (regWrite && regAddr == wwd_pkg::REG_INTSTAT) begin
            intStatus <= (intStatus & ~regWdata[wwd_pkg::INT_W-1:0]) | intEvent;
        end else begin
            intStatus <= intStatus | intEvent;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            intMask <= wwd_pkg::INT_RESET;
        end else if (regWrite && regAddr == wwd_pkg::REG_INTMASK) begin
            intMask <= regWdata[wwd_pkg::INT_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(intStatus & intMask);
        end
    end

    // Read data stands in the cycle after the read strobe only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= '0;
        end else if (regRead) begin
            case (regAddr)
                wwd_pkg::REG_RSTCTL: begin
                    regRdata <= wwd_pkg::RSTCTL_RESET | {10'h0, swEnable, timeoutFlag, sleepFlag, idleFlag, 2'h0};
                end
                wwd_pkg::REG_CONFIG: begin
                    regRdata <= config_word;
                end
                wwd_pkg::REG_INTSTAT: begin
                    regRdata <= {13'h0, intStatus};
                end
                wwd_pkg::REG_INTMASK: begin
                    regRdata <= {13'h0, intMask};
                end
                default: begin
                    regRdata <= '0;
                end
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    AST_SLEEP_RUNS: assert property (@(posedge clk) disable iff (!rstn)
        (state == wwd_pkg::ST_DOZE && enabled && tbLink.tick && !tbLink.clear) |=> $changed(timebase.preCnt))
        else $error("Watchdog halted in low power");

    AST_WAKE_PULSE: assert property (@(posedge clk) disable iff (!rstn)
        dozeTimeout |=> wakeRequest && !deviceReset ##1 (state == wwd_pkg::ST_RUN) && !wakeRequest)
        else $error("Low-power time-out did not wake");

    AST_ALWAYS_ON: assert property (@(posedge clk) disable iff (!rstn)
        (enableCfg == wwd_pkg::EN_ALWAYS) ##1 (enableCfg == wwd_pkg::EN_ALWAYS) |-> oscEnable)
        else $error("Forced enable not honoured");

    AST_SOFT_OFF: assert property (@(posedge clk) disable iff (!rstn)
        (enableCfg == wwd_pkg::EN_SOFT && !swEnable) |-> !tbLink.run ##1 !tbLink.timeout)
        else $error("Watchdog ran with software enable clear");

    AST_RESET_CLEARS_SWEN: assert property (@(posedge clk) disable iff (!rstn)
        deviceReset |-> !swEnable)
        else $error("Software enable survived a watchdog reset");

    AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rstn)
        timeoutFlag && !wrRstCtl |=> timeoutFlag)
        else $error("Time-out flag cleared by hardware");

    AST_EARLY_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
        (runClear && enabled && !config_word[wwd_pkg::CFG_WINDOW_MODE_DISABLE_BIT] && !tbLink.windowOpen)
        |=> deviceReset && timeoutFlag)
        else $error("Early clear did not reset");

    AST_RUN_TIMEOUT: assert property (@(posedge clk) disable iff (!rstn)
        runTimeout |=> deviceReset && timeoutFlag && intStatus[wwd_pkg::INT_TIMEOUT])
        else $error("Running time-out did not reset");

    AST_PSAVE_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
        $rose(state == wwd_pkg::ST_RESUME) |=> (timebase.preCnt == '0) && (timebase.postCnt == '0))
        else $error("Counters not cleared on wake");

    AST_WINDOW_CLEAR_OK: assert property (@(posedge clk) disable iff (!rstn)
        (runClear && tbLink.windowOpen && !tbLink.timeout) |=> !deviceReset)
        else $error("Clear inside the window caused a reset");

    AST_DOZE_FLAG: assert property (@(posedge clk) disable iff (!rstn)
        dozeTimeout |=> timeoutFlag && intStatus[wwd_pkg::INT_WAKE])
        else $error("Low-power time-out left no flag");

    AST_SLEEP_FLAG_SET: assert property (@(posedge clk) disable iff (!rstn)
        (powerSaveInstr && state == wwd_pkg::ST_RUN && !issueReset) |=> ($past(powerSaveSleep) ? sleepFlag : idleFlag))
        else $error("Sleep or idle flag not set");

    AST_OSC_FOLLOWS: assert property (@(posedge clk) disable iff (!rstn)
        oscEnable == $past(enabled))
        else $error("Oscillator enable does not follow watchdog enable");
endmodule : wwd_watchdog

// ### verification/wwd_watchdog_tb.sv
// Self-checking testbench of the windowed watchdog
module wwd_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic lowPowerOsc = 1'b0;
    logic powerSaveInstr = 1'b0;
    logic powerSaveSleep = 1'b0;
    logic clearInstr = 1'b0;
    logic clockSwitchDone = 1'b0;
    logic otherWake = 1'b0;
    logic [15:0] regRdata;
    logic oscEnable;
    logic wakeRequest;
    logic deviceReset;
    logic lowPower;
    logic irq;
    logic rdTaken = 1'b0;
    logic [15:0] rdQ[$];
    logic [15:0] evQ[$];
    logic [15:0] cfgs [3] = '{16'h0c81, 16'h0c82, 16'h0c90};
    int lens [3] = '{64, 128, 128};
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 32'hf3cc;
    logic [31:0] r;

    wwd_watchdog u_dut (
        .clk,
        .rstn,
        .regAddr,
        .regWdata,
        .regWrite,
        .regRead,
        .regRdata,
        .lowPowerOsc,
        .powerSaveInstr,
        .powerSaveSleep,
        .clearInstr,
        .clockSwitchDone,
        .otherWake,
        .oscEnable,
        .wakeRequest,
        .deviceReset,
        .lowPower,
        .irq
    );

    always #50 clk = ~clk;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        rdQ.push_back(e);
        @(posedge clk);
        regRead <= 1'b0;
    endtask : rd

    // One oscillator period is six system clocks
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            lowPowerOsc <= 1'b1;
            repeat (3) @(posedge clk);
            lowPowerOsc <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask : tick

    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: clearInstr <= 1'b1;
            1: powerSaveInstr <= 1'b1;
            2: clockSwitchDone <= 1'b1;
            default: otherWake <= 1'b1;
        endcase
        @(posedge clk);
        clearInstr <= 1'b0;
        powerSaveInstr <= 1'b0;
        clockSwitchDone <= 1'b0;
        otherWake <= 1'b0;
    endtask : pulse

    // Arm one expected pulse (1 reset, 2 wake), then give the final tick or a clear
    task automatic last(input logic [15:0] code, input bit byClear);
        evQ.push_back(code);
        if (byClear) begin
            pulse(0);
        end else begin
            tick(1);
        end
        repeat (30) if (evQ.size() != 0) @(posedge clk);
        chk(16'(evQ.size()), 16'h0000);
        evQ.delete();
    endtask : last

    always @(posedge clk) rdTaken <= regRead;

    // Read data and event pulses are judged against the oldest note
    always @(negedge clk) begin
        if (rdTaken) begin
            chk(regRdata, rdQ.pop_front());
        end
        if (deviceReset === 1'b1 || wakeRequest === 1'b1) begin
            chk({14'h0, wakeRequest, deviceReset}, evQ.size() != 0 ? evQ.pop_front() : 16'h0000);
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rd(wwd_pkg::REG_RSTCTL, 16'h0000);
        rd(wwd_pkg::REG_CONFIG, 16'h089f);
        rd(wwd_pkg::REG_INTSTAT, 16'h0000);
        rd(4'h2, 16'h0000);
        r = $random(seed);
        wr(wwd_pkg::REG_INTMASK, r[15:0]);
        rd(wwd_pkg::REG_INTMASK, {13'h0, r[2:0]});
        wr(4'h6, r[31:16]);
        rd(4'h6, 16'h0000);
        wr(wwd_pkg::REG_INTMASK, 16'h0007);
        // Software-enable mode
        wr(wwd_pkg::REG_CONFIG, 16'h0880);
        tick(40);
        chk(oscEnable, 16'h0000);
        wr(wwd_pkg::REG_RSTCTL, 16'h0020);
        repeat (3) @(posedge clk);
        chk(oscEnable, 16'h0001);
        tick(31);
        last(16'h0001, 0);
        rd(wwd_pkg::REG_RSTCTL, 16'h0010);
        chk(irq, 16'h0001);
        rd(wwd_pkg::REG_INTSTAT, 16'h0001);
        wr(wwd_pkg::REG_INTSTAT, 16'h0001);
        repeat (2) @(posedge clk);
        chk(irq, 16'h0000);
        rd(wwd_pkg::REG_RSTCTL, 16'h0010);
        wr(wwd_pkg::REG_RSTCTL, 16'h0000);
        rd(wwd_pkg::REG_RSTCTL, 16'h0000);
        // Always-on mode, divider ratios
        foreach (cfgs[i]) begin
            wr(wwd_pkg::REG_CONFIG, cfgs[i]);
            pulse(2);
            tick(lens[i] - 1);
            last(16'h0001, 0);
        end
        wr(wwd_pkg::REG_CONFIG, 16'h0c80);
        pulse(2);
        tick(20);
        pulse(0);
        tick(31);
        last(16'h0001, 0);
        // Sleep then idle
        wr(wwd_pkg::REG_RSTCTL, 16'h0000);
        pulse(2);
        tick(10);
        powerSaveSleep <= 1'b1;
        pulse(1);
        repeat (2) @(posedge clk);
        chk(lowPower, 16'h0001);
        rd(wwd_pkg::REG_RSTCTL, 16'h0008);
        pulse(0);
        tick(31);
        last(16'h0002, 0);
        repeat (3) @(posedge clk);
        chk(lowPower, 16'h0000);
        rd(wwd_pkg::REG_RSTCTL, 16'h0018);
        wr(wwd_pkg::REG_RSTCTL, 16'h0000);
        powerSaveSleep <= 1'b0;
        pulse(1);
        rd(wwd_pkg::REG_RSTCTL, 16'h0004);
        pulse(3);
        repeat (3) @(posedge clk);
        chk(lowPower, 16'h0000);
        // Windowed mode
        wr(wwd_pkg::REG_INTSTAT, 16'h0007);
        // Clear inside the second half of a two-step period is accepted
        wr(wwd_pkg::REG_CONFIG, 16'h0c01);
        pulse(2);
        tick(40);
        pulse(0);
        tick(63);
        last(16'h0001, 0);
        wr(wwd_pkg::REG_INTSTAT, 16'h0001);
        wr(wwd_pkg::REG_INTMASK, 16'h0003);
        wr(wwd_pkg::REG_CONFIG, 16'h0f04);
        pulse(2);
        tick(20);
        last(16'h0001, 1);
        repeat (2) @(posedge clk);
        chk(irq, 16'h0000);
        rd(wwd_pkg::REG_INTSTAT, 16'h0004);
        wr(wwd_pkg::REG_INTMASK, 16'h0004);
        repeat (2) @(posedge clk);
        chk(irq, 16'h0001);
        results();
    end

endmodule : wwd_watchdog_tb
